// ### adc_regs.svh
// Contract
// - Raw high byte shows the live approximation register and moves during conversion.
// - Result high byte holds the last finished conversion until the next completes, or until a disable landing on a step tick loads the partial code.
// - Two low result bits sit in bits 7 and 6 of the low-bits register.
// - Reading the result high byte latches the matching low bits for a later read.
// - Result registers are not reset; contents undefined until a conversion finishes.
// - Five-bit settling count in system clocks, resets to ones; software ensures 0.5 us.
// - Six-bit sample/hold count in system clocks, resets to ones; software ensures 1 us.
// - Prescale bits 0..3 divide the system clock by 2, 4, 8, 16.
// - With no prescale bit set the converter clock is the undivided system clock.
// - Writing one to start with enable one in the same write begins a conversion; read shows one while busy.
// - Three-bit channel select picks one of eight inputs by its binary value.
// - Converter enable zero holds the converter off; one allows conversions.
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ADC_IDX_CTRL       12'hf70
`define ADC_IDX_RAW_HIGH   12'hf71
`define ADC_IDX_RES_HIGH   12'hf72
`define ADC_IDX_RES_LOW    12'hf73
`define ADC_IDX_SETTLE     12'hf74
`define ADC_IDX_SAMPLE     12'hf75
`define ADC_IDX_PRESCALE   12'hf76

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADC_CTRL_START     7
`define ADC_CTRL_REFEN     5
`define ADC_CTRL_EN        4
`define ADC_CTRL_CH_LSB    0
`define ADC_CTRL_CH_W      3
`define ADC_SETTLE_W       5
`define ADC_SAMPLE_W       6
`define ADC_PRESCALE_W     4
`define ADC_RES_W          10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ADC_CTRL_RST       7'h00
`define ADC_SETTLE_RST     5'h1f
`define ADC_SAMPLE_RST     6'h3f
`define ADC_PRESCALE_RST   4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADC_CLK_PERIOD_PS  40000
`define ADC_SETTLE_MIN_PS  500000
`define ADC_SAMPLE_MIN_PS  1000000
`define ADC_SETTLE_MIN_CYC ((`ADC_SETTLE_MIN_PS + `ADC_CLK_PERIOD_PS - 1) / `ADC_CLK_PERIOD_PS)
`define ADC_SAMPLE_MIN_CYC ((`ADC_SAMPLE_MIN_PS + `ADC_CLK_PERIOD_PS - 1) / `ADC_CLK_PERIOD_PS)

`endif

// ### adc_pkg.sv
package adc_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [1:0] htrans_t;
  typedef logic [11:0] reg_idx_t;

  typedef enum logic [2:0] {
    CONV_IDLE,
    CONV_SAMPLE,
    CONV_SETTLE,
    CONV_STEP
  } conv_state_t;

endpackage

// ### adc_clock_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.svh"

module adc_clock_prescaler (
  // Clock and reset
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  // Divide select
  input  wire logic [`ADC_PRESCALE_W-1:0]   div_sel,
  // Converter clock enable
  output logic                              conv_tick
);

  logic [3:0] cnt_r;
  logic [3:0] lim;

  // ----------------------------------------------------------------
  // Divide limit, highest set bit wins
  // ----------------------------------------------------------------
  always_comb begin
    if (div_sel[3]) begin
      lim = 4'hf;
    end else if (div_sel[2]) begin
      lim = 4'h7;
    end else if (div_sel[1]) begin
      lim = 4'h3;
    end else if (div_sel[0]) begin
      lim = 4'h1;
    end else begin
      lim = 4'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r     <= 4'h0;
      conv_tick <= 1'b0;
    end else begin
      conv_tick <= (cnt_r >= lim);
      cnt_r     <= (cnt_r >= lim) ? 4'h0 : cnt_r + 4'h1;
    end
  end

endmodule
`default_nettype wire

// ### adc_result_and_timing_regs.sv
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.svh"

module adc_result_and_timing_regs (
  // Clock and reset
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  // AHB-Lite slave
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire adc_pkg::htrans_t             htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic [31:0]                       hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  // Analog core
  input  wire logic                         comparator_in,
  output logic [`ADC_RES_W-1:0]             dac_code,
  output logic                              sample_hold,
  output logic [`ADC_CTRL_CH_W-1:0]         input_channel_select,
  output logic                              converter_enable,
  output logic                              reference_enable,
  output logic                              converter_clock_tick
);
  import adc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  conv_state_t                state_r;
  conv_state_t                state_nxt;
  logic [6:0]                 ctrl_r;
  logic [`ADC_SETTLE_W-1:0]   settling_count_r;
  logic [`ADC_SAMPLE_W-1:0]   sample_hold_count_field_r;
  logic [`ADC_PRESCALE_W-1:0] prescale_r;
  logic [`ADC_RES_W-1:0]      sar_r;
  logic [`ADC_RES_W-1:0]      result_r;
  logic [1:0]                 result_low_bits_r;
  logic [5:0]                 phase_cnt_r;
  logic [3:0]                 bit_idx_r;
  logic                       done_r;
  logic                       result_valid_r;
  logic                       cmp_s1_r;
  logic                       cmp_s2_r;
  logic                       cmp_s3_r;
  logic                       cmp_r;
  logic                       rd_pend_r;
  logic                       wr_pend_r;
  reg_idx_t                   rd_idx_r;
  reg_idx_t                   wr_idx_r;
  logic                       tick;
  logic                       step_tick;
  logic                       step_armed_r;
  logic                       accept;
  logic                       ctl_wr;
  logic                       start_req;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [31:0] a, input reg_idx_t idx);
    addr_hit = (a == {18'h0, idx, 2'b00});
  endfunction

  function automatic logic addr_mapped(input logic [31:0] a);
    addr_mapped = (a[31:14] == 18'h0) && (a[1:0] == 2'b00) &&
                  (a[13:2] >= `ADC_IDX_CTRL) && (a[13:2] <= `ADC_IDX_PRESCALE);
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign accept = hsel && htrans[1] && hready;
  assign ctl_wr = wr_pend_r && (wr_idx_r == `ADC_IDX_CTRL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_r <= 1'b0;
      wr_pend_r <= 1'b0;
      rd_idx_r  <= 12'h000;
      wr_idx_r  <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      rd_pend_r <= accept && !hwrite && addr_mapped(haddr);
      wr_pend_r <= accept && hwrite && addr_mapped(haddr);
      if (accept) begin
        rd_idx_r <= haddr[13:2];
        wr_idx_r <= haddr[13:2];
      end
      hreadyout <= !(accept && !hwrite);
      hresp     <= 1'b0;
    end
  end

  // Read data, one wait state so a preceding write is visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (rd_pend_r) begin
      unique case (rd_idx_r)
        `ADC_IDX_CTRL:     hrdata <= {24'h0, state_r != CONV_IDLE, ctrl_r};
        `ADC_IDX_RAW_HIGH: hrdata <= {24'h0, sar_r[9:2]};
        `ADC_IDX_RES_HIGH: hrdata <= {24'h0, result_r[9:2]};
        `ADC_IDX_RES_LOW:  hrdata <= {24'h0, result_low_bits_r, 6'h00};
        `ADC_IDX_SETTLE:   hrdata <= {27'h0, settling_count_r};
        `ADC_IDX_SAMPLE:   hrdata <= {26'h0, sample_hold_count_field_r};
        `ADC_IDX_PRESCALE: hrdata <= {28'h0, prescale_r};
        default:           hrdata <= 32'h0;
      endcase
    end else begin
      hrdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r                    <= `ADC_CTRL_RST;
      settling_count_r          <= `ADC_SETTLE_RST;
      sample_hold_count_field_r <= `ADC_SAMPLE_RST;
      prescale_r                <= `ADC_PRESCALE_RST;
    end else if (wr_pend_r) begin
      unique case (wr_idx_r)
        `ADC_IDX_CTRL:     ctrl_r <= hwdata[6:0];
        `ADC_IDX_SETTLE:   settling_count_r <= hwdata[`ADC_SETTLE_W-1:0];
        `ADC_IDX_SAMPLE:   sample_hold_count_field_r <= hwdata[`ADC_SAMPLE_W-1:0];
        `ADC_IDX_PRESCALE: prescale_r <= hwdata[`ADC_PRESCALE_W-1:0];
        default:           ctrl_r <= ctrl_r;
      endcase
    end
  end

  assign start_req = ctl_wr && hwdata[`ADC_CTRL_START] && hwdata[`ADC_CTRL_EN];

  // ----------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      cmp_s3_r <= 1'b0;
      cmp_r    <= 1'b0;
    end else begin
      cmp_s1_r <= comparator_in;
      cmp_s2_r <= cmp_s1_r;
      cmp_s3_r <= cmp_s2_r;
      if (cmp_s2_r == cmp_s3_r) begin
        cmp_r <= cmp_s3_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Converter clock
  // ----------------------------------------------------------------
  adc_clock_prescaler adc_clock_prescaler_inst (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .div_sel   (prescale_r),
    .conv_tick (tick)
  );

  // First tick after entry only arms, so the comparator sees the new code
  assign step_tick = tick && step_armed_r;

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CONV_IDLE: begin
        if (start_req) begin
          state_nxt = CONV_SAMPLE;
        end
      end
      CONV_SAMPLE: begin
        if (phase_cnt_r <= 6'h01) begin
          state_nxt = CONV_SETTLE;
        end
      end
      CONV_SETTLE: begin
        if (phase_cnt_r <= 6'h01) begin
          state_nxt = CONV_STEP;
        end
      end
      CONV_STEP: begin
        if (step_tick && bit_idx_r == 4'h0) begin
          state_nxt = CONV_IDLE;
        end
      end
    endcase
    if (!ctrl_r[`ADC_CTRL_EN] && !ctl_wr) begin
      state_nxt = CONV_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= CONV_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Interval counter for sample/hold and settling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_cnt_r <= 6'h00;
    end else if (state_r == CONV_IDLE && state_nxt == CONV_SAMPLE) begin
      phase_cnt_r <= sample_hold_count_field_r;
    end else if (state_r == CONV_SAMPLE && state_nxt == CONV_SETTLE) begin
      phase_cnt_r <= {1'b0, settling_count_r};
    end else if (phase_cnt_r != 6'h00) begin
      phase_cnt_r <= phase_cnt_r - 6'h01;
    end
  end

  // Successive approximation, one bit per converter clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sar_r        <= 10'h000;
      bit_idx_r    <= 4'h0;
      step_armed_r <= 1'b0;
    end else if (state_r == CONV_SETTLE && state_nxt == CONV_STEP) begin
      sar_r        <= 10'h200;
      bit_idx_r    <= 4'h9;
      step_armed_r <= 1'b0;
    end else if (state_r == CONV_STEP && tick) begin
      step_armed_r <= 1'b1;
      if (step_armed_r) begin
        sar_r[bit_idx_r] <= cmp_r;
        if (bit_idx_r != 4'h0) begin
          sar_r[bit_idx_r - 4'h1] <= 1'b1;
          bit_idx_r               <= bit_idx_r - 4'h1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_r         <= 1'b0;
      result_valid_r <= 1'b0;
    end else begin
      done_r <= (state_r == CONV_STEP) && (state_nxt == CONV_IDLE) && step_tick;
      if (done_r) begin
        result_valid_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result registers, no reset
  // ----------------------------------------------------------------
  always_ff @(posedge hclk) begin
    if (done_r) begin
      result_r <= sar_r;
    end
  end

  always_ff @(posedge hclk) begin
    if (rd_pend_r && rd_idx_r == `ADC_IDX_RES_HIGH) begin
      result_low_bits_r <= result_r[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Analog core outputs
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dac_code             <= 10'h000;
      sample_hold          <= 1'b0;
      input_channel_select <= 3'h0;
      converter_enable     <= 1'b0;
      reference_enable     <= 1'b0;
      converter_clock_tick <= 1'b0;
    end else begin
      dac_code             <= sar_r;
      sample_hold          <= (state_nxt == CONV_SAMPLE);
      input_channel_select <= ctrl_r[`ADC_CTRL_CH_LSB +: `ADC_CTRL_CH_W];
      converter_enable     <= ctrl_r[`ADC_CTRL_EN];
      reference_enable     <= ctrl_r[`ADC_CTRL_REFEN];
      converter_clock_tick <= tick;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_start_busy: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == CONV_IDLE && start_req |=> state_r == CONV_SAMPLE ##1 state_r != CONV_IDLE)
    else $error("start did not make the converter busy");

  a_raw_live: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_r && rd_idx_r == `ADC_IDX_RAW_HIGH |=> hrdata[7:0] == $past(sar_r[9:2]))
    else $error("raw byte does not follow approximation register");

  a_result_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    result_valid_r && !done_r |=> $stable(result_r))
    else $error("result changed without a finished conversion");

  a_low_position: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_r && rd_idx_r == `ADC_IDX_RES_LOW && result_valid_r
    |=> hrdata[5:0] == 6'h00 && hrdata[7:6] == $past(result_low_bits_r))
    else $error("low bits not in bits 7 and 6");

  a_low_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_r && rd_idx_r == `ADC_IDX_RES_HIGH && result_valid_r
    |=> result_low_bits_r == $past(result_r[1:0]))
    else $error("low bits not captured on high byte read");

  a_sample_len: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == CONV_SAMPLE && phase_cnt_r > 6'h01 && ctrl_r[`ADC_CTRL_EN]
    |=> state_r == CONV_SAMPLE && phase_cnt_r == $past(phase_cnt_r) - 6'h01)
    else $error("sample interval ended early");

  a_settle_entry: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == CONV_SAMPLE && phase_cnt_r <= 6'h01 && ctrl_r[`ADC_CTRL_EN]
    |=> state_r == CONV_SETTLE && phase_cnt_r == {1'b0, $past(settling_count_r)})
    else $error("settling interval not loaded");

  a_div_none: assert property (@(posedge hclk) disable iff (!hresetn)
    prescale_r == 4'h0 ##1 prescale_r == 4'h0 ##1 prescale_r == 4'h0 |-> tick)
    else $error("undivided converter clock missed a cycle");

  a_div_two: assert property (@(posedge hclk) disable iff (!hresetn)
    tick && prescale_r == 4'h1 ##1 prescale_r == 4'h1 |-> !tick ##1 tick)
    else $error("divide by two period wrong");

  a_step_done: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == CONV_STEP && step_tick && bit_idx_r == 4'h0 && ctrl_r[`ADC_CTRL_EN]
    |=> state_r == CONV_IDLE && done_r ##1 result_r == $past(sar_r))
    else $error("conversion end did not update result");

  a_enable_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_r[`ADC_CTRL_EN] && !ctl_wr |=> state_r == CONV_IDLE)
    else $error("converter ran while disabled");

endmodule
`default_nettype wire

// ### adc_analog_core_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.svh"

module adc_analog_core_model #(
  parameter int DELAY = 0
) (
  // Clock
  input  wire logic                       hclk,
  // Analog levels, ten bits per channel
  input  wire logic [79:0]                levels,
  // Converter side
  input  wire logic [`ADC_RES_W-1:0]      dac_code,
  input  wire logic                       sample_hold,
  input  wire logic [`ADC_CTRL_CH_W-1:0]  input_channel_select,
  input  wire logic                       converter_enable,
  output logic                            comparator_in
);
  logic [`ADC_RES_W-1:0] held_r;
  logic [7:0]            pipe_r;
  logic                  junk_r = 1'b0;

  // ----------------------------------------------------------------
  // Sampling and comparison
  // ----------------------------------------------------------------
  always_ff @(posedge hclk) begin
    if (sample_hold) begin
      held_r <= levels[input_channel_select*10 +: 10];
    end
    pipe_r <= {pipe_r[6:0], held_r >= dac_code};
    junk_r <= ~junk_r;
  end

  // Disabled core gives a toggling level, slow core answers late
  assign comparator_in = !converter_enable ? junk_r :
                         (DELAY == 0) ? (held_r >= dac_code) :
                         pipe_r[(DELAY > 0) ? DELAY-1 : 0];
endmodule
`default_nettype wire

// ### adc_result_and_timing_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.svh"

module adc_result_and_timing_regs_test;
  typedef struct {
    string       nm;
    logic [31:0] exp;
    logic [31:0] msk;
  } note_t;

  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        comparator_in;
  logic [9:0]  dac_code;
  logic        sample_hold;
  logic [2:0]  input_channel_select;
  logic        converter_enable;
  logic        reference_enable;
  logic        converter_clock_tick;
  logic [79:0] levels = 80'h0;
  note_t       notes[$];
  note_t       nt;
  int          mismatches = 0;
  int          check_count = 0;
  int          ticks = 0;
  int          sh_len = 0;
  int          sh_exp = 0;
  int          t0;
  int          n;
  logic        rd_phase = 1'b0;
  logic [31:0] lfsr = 32'hf33641e7;
  logic [31:0] last_rd;
  logic [9:0]  val;
  logic [7:0]  ctl;

  always #20 hclk = ~hclk;

  adc_result_and_timing_regs adc_result_and_timing_regs_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .comparator_in(comparator_in), .dac_code(dac_code), .sample_hold(sample_hold),
    .input_channel_select(input_channel_select), .converter_enable(converter_enable),
    .reference_enable(reference_enable), .converter_clock_tick(converter_clock_tick));

  adc_analog_core_model #(.DELAY(2)) adc_analog_core_model_inst (
    .hclk(hclk), .levels(levels), .dac_code(dac_code), .sample_hold(sample_hold),
    .input_channel_select(input_channel_select), .converter_enable(converter_enable),
    .comparator_in(comparator_in));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] got);
    check_count++;
    if (got !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, got);
    end
  endtask

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {18'h0, idx, 2'b00};
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    wait_ready();
    last_rd = hrdata;
  endtask

  task automatic rd(input logic [11:0] idx, input logic [31:0] e, input logic [31:0] m,
                    input string nm);
    notes.push_back('{nm, e, m});
    bus(1'b0, idx, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Output watcher
  // ----------------------------------------------------------------
  always @(posedge hclk) begin
    if (rd_phase && hreadyout === 1'b1) begin
      nt = notes.pop_front();
      check(nt.nm, nt.exp & nt.msk, hrdata & nt.msk);
      check("hresp", 32'h0, {31'h0, hresp});
    end
    if (hreadyout === 1'b1) begin
      rd_phase <= hsel && htrans[1] && !hwrite;
    end
    ticks <= ticks + int'(converter_clock_tick === 1'b1);
    if (sample_hold === 1'b1) begin
      sh_len <= sh_len + 1;
    end else if (sh_len != 0) begin
      check("sample_hold cycles", sh_exp, sh_len);
      sh_len <= 0;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`ADC_IDX_SETTLE, 32'h1f, 32'hffffffff, "settle reset");
    rd(`ADC_IDX_SAMPLE, 32'h3f, 32'hffffffff, "sample reset");
    rd(`ADC_IDX_PRESCALE, 32'h0, 32'hffffffff, "prescale reset");
    rd(`ADC_IDX_CTRL, 32'h0, 32'hffffffff, "control reset");
    rd(12'hf77, 32'h0, 32'hffffffff, "unmapped");
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      bus(1'b1, `ADC_IDX_SETTLE, {27'h0, lfsr[4:0]});
      bus(1'b1, `ADC_IDX_SAMPLE, {26'h0, lfsr[13:8]});
      rd(`ADC_IDX_SETTLE, {27'h0, lfsr[4:0]}, 32'hffffffff, "settle");
      rd(`ADC_IDX_SAMPLE, {26'h0, lfsr[13:8]}, 32'hffffffff, "sample");
    end
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, `ADC_IDX_PRESCALE, (i == 0) ? 32'h0 : 32'h1 << (i - 1));
      rd(`ADC_IDX_PRESCALE, (i == 0) ? 32'h0 : 32'h1 << (i - 1), 32'hff, "prescale");
      repeat (20) @(posedge hclk);
      t0 = ticks;
      repeat (64) @(posedge hclk);
      check("converter ticks", 64 >> i, ticks - t0);
    end
    bus(1'b1, `ADC_IDX_SETTLE, `ADC_SETTLE_MIN_CYC);
    bus(1'b1, `ADC_IDX_SAMPLE, `ADC_SAMPLE_MIN_CYC);
    rd(`ADC_IDX_SETTLE, `ADC_SETTLE_MIN_CYC, 32'hffffffff, "settle min");
    rd(`ADC_IDX_SAMPLE, `ADC_SAMPLE_MIN_CYC, 32'hffffffff, "sample min");
    sh_exp = `ADC_SAMPLE_MIN_CYC;
    for (int ch = 0; ch < 8; ch++) begin
      lfsr = next_rand(lfsr);
      val = lfsr[9:0];
      levels[ch*10 +: 10] <= val;
      ctl = 8'h90 | 8'(ch) | {2'b00, ch[0], 5'h00};
      bus(1'b1, `ADC_IDX_CTRL, {24'h0, ctl});
      rd(`ADC_IDX_CTRL, {24'h0, ctl}, 32'hff, "busy");
      check("channel select", 32'(ch), {29'h0, input_channel_select});
      check("converter enable", 32'h1, {31'h0, converter_enable});
      check("reference enable", {31'h0, ctl[5]}, {31'h0, reference_enable});
      n = 0;
      do begin
        rd(`ADC_IDX_CTRL, {24'h0, ctl}, 32'h7f, "control while busy");
        n++;
      end while (last_rd[7] !== 1'b0 && n < 100);
      if (last_rd[7] !== 1'b0) begin
        mismatches++;
        print_verdict();
      end
      rd(`ADC_IDX_RES_HIGH, {24'h0, val[9:2]}, 32'hffffffff, "result high");
      rd(`ADC_IDX_RES_LOW, {24'h0, val[1:0], 6'h0}, 32'hffffffff, "result low");
      rd(`ADC_IDX_RAW_HIGH, {24'h0, val[9:2]}, 32'hffffffff, "raw high");
      check("dac code", {22'h0, val}, {22'h0, dac_code});
    end
    // Start with the converter disabled must leave the result alone
    levels <= ~levels;
    bus(1'b1, `ADC_IDX_CTRL, 32'h87);
    rd(`ADC_IDX_CTRL, 32'h07, 32'hff, "start refused");
    check("converter enable", 32'h0, {31'h0, converter_enable});
    repeat (200) @(posedge hclk);
    bus(1'b1, `ADC_IDX_RES_LOW, 32'hc0);
    rd(`ADC_IDX_RES_HIGH, {24'h0, val[9:2]}, 32'hffffffff, "result held");
    rd(`ADC_IDX_RES_LOW, {24'h0, val[1:0], 6'h0}, 32'hffffffff, "low held");
    repeat (4) @(posedge hclk);
    print_verdict();
  end
endmodule
`default_nettype wire
